// ===== src/pmp_pkg.sv
// Constants and types shared by the program memory partition map
package pmp_pkg;

   // Program address space
   localparam int          PMP_PC_W       = 15;
   localparam int          PMP_PM_AW      = 13;
   localparam int          PMP_WORD_W     = 14;
   localparam logic [14:0] PMP_RESET_VEC  = 15'h0000;
   localparam logic [14:0] PMP_IRQ_VEC    = 15'h0004;
   localparam logic [12:0] PMP_LAST_ADDR  = 13'h1fff;
   localparam logic [12:0] PMP_STORE_SPAN = 13'h0080;
   localparam logic [12:0] PMP_STORE_BASE = PMP_LAST_ADDR + 13'h0001 - PMP_STORE_SPAN;

   // Boot region end addresses by size code
   localparam logic [12:0] PMP_BOOT_END_512  = 13'h01ff;
   localparam logic [12:0] PMP_BOOT_END_1K   = 13'h03ff;
   localparam logic [12:0] PMP_BOOT_END_2K   = 13'h07ff;
   localparam logic [12:0] PMP_BOOT_END_4K   = 13'h0fff;
   localparam logic [12:0] PMP_BOOT_END_8K   = 13'h1fff;
   localparam logic [12:0] PMP_BOOT_END_HALF = PMP_LAST_ADDR >> 1;
   localparam logic [2:0]  PMP_BSZ_512       = 3'h7;
   localparam logic [2:0]  PMP_BSZ_1K        = 3'h6;
   localparam logic [2:0]  PMP_BSZ_2K        = 3'h5;
   localparam logic [2:0]  PMP_BSZ_4K        = 3'h4;
   localparam logic [2:0]  PMP_BSZ_8K        = 3'h3;

   // High address space: pointer bit and configuration word range
   localparam int          PMP_HIGH_BIT  = 15;
   localparam logic [15:0] PMP_CFG_FIRST = 16'h8007;
   localparam logic [15:0] PMP_CFG_LAST  = 16'h800b;

   // Register word indices, byte address is four times the index
   localparam logic [15:0] PMP_IDX_REV  = 16'h8005;
   localparam logic [15:0] PMP_IDX_DEV  = 16'h8006;
   localparam logic [15:0] PMP_IDX_CFG  = 16'h8010;
   localparam logic [15:0] PMP_IDX_STAT = 16'h8011;

   // Fixed top bits of identity and revision words
   localparam logic [1:0] PMP_DEV_TOP = 2'b11;
   localparam logic [1:0] PMP_REV_TOP = 2'b10;

   // Identity defaults, values arbitrary
   localparam logic [11:0] PMP_PART_CODE_DFLT = 12'h5a1;
   localparam logic [5:0]  PMP_MAJOR_DFLT     = 6'h01;
   localparam logic [5:0]  PMP_MINOR_DFLT     = 6'h00;

   // Partition configuration word fields
   localparam int         PMP_CFG_W          = 10;
   localparam int         PMP_CFG_SIZE_LSB   = 0;
   localparam int         PMP_CFG_BOOT_EN_N  = 3;
   localparam int         PMP_CFG_STORE_EN_N = 4;
   localparam int         PMP_CFG_APP_LOCK_N = 7;
   localparam int         PMP_CFG_BOOT_LOCK_N = 8;
   localparam int         PMP_CFG_CFG_LOCK_N = 9;
   localparam logic [9:0] PMP_CFG_RESET      = 10'h39f;
   localparam logic [9:0] PMP_CFG_LOCK_MASK  = 10'h380;
   localparam logic [9:0] PMP_CFG_SIZE_MASK  = 10'h007;

   // Status word fields
   localparam int PMP_ST_WR_ERR  = 0;
   localparam int PMP_ST_EXEC_OK = 1;

   typedef enum logic {PMP_IND_IDLE, PMP_IND_WAIT} pmp_ind_t;

   typedef struct packed {
      logic        waitreq;
      logic [31:0] rdata;
      logic [14:0] pc;
      logic [12:0] fetch_addr;
      logic [9:0]  cfg;
      logic        wr_err;
      logic        exec_ok;
      pmp_ind_t    ind;
      logic        pm_rd;
      logic [12:0] pm_addr;
      logic        ind_busy;
      logic        ind_valid;
      logic [7:0]  ind_data;
      logic        dmem_sel;
      logic        nvm_go;
      logic [15:0] nvm_addr;
      logic        mv_reset;
   } pmp_state_t;

   localparam pmp_state_t PMP_STATE_RST = '{waitreq: 1'b1, cfg: PMP_CFG_RESET,
                                            exec_ok: 1'b1, ind: PMP_IND_IDLE,
                                            default: '0};

endpackage

// ===== src/pmp_part_dec.sv
// Partition decoder: boot, application and storage membership of one address
`timescale 1ns/10ps
module pmp_part_dec
   import pmp_pkg::*;
(
   // Address and partition settings
   input  wire logic [12:0] addr_in,
   input  wire logic        boot_en_n_in,
   input  wire logic        store_en_n_in,
   input  wire logic [2:0]  size_in,
   // Membership
   output logic             in_boot_out,
   output logic             in_app_out,
   output logic             in_store_out
);

   // Sizes above half the memory fall back to half
   function automatic logic [12:0] boot_end(input logic [2:0] sz);
      logic [12:0] e;
      e = PMP_BOOT_END_HALF;
      unique case (sz)
         PMP_BSZ_512: e = PMP_BOOT_END_512;
         PMP_BSZ_1K:  e = PMP_BOOT_END_1K;
         PMP_BSZ_2K:  e = PMP_BOOT_END_2K;
         PMP_BSZ_4K:  e = PMP_BOOT_END_4K;
         PMP_BSZ_8K:  e = PMP_BOOT_END_8K;
         default:     e = PMP_BOOT_END_HALF;
      endcase
      if (e > PMP_BOOT_END_HALF) begin
         e = PMP_BOOT_END_HALF;
      end
      return e;
   endfunction

   always_comb begin
      in_boot_out  = !boot_en_n_in && (addr_in <= boot_end(size_in));
      in_store_out = !store_en_n_in && (addr_in >= PMP_STORE_BASE);
      in_app_out   = !in_boot_out && !in_store_out;
   end

endmodule

// ===== src/pmp_map.sv
// Program memory partition map: program counter, indirect reads, partitions, identity
//
// What this block does
// - Identity word is read-only; bits 13:12 read one, bits 11:0 the part code.
// - Revision word is read-only; bit 13 reads one, bit 12 reads zero.
// - Revision word holds major revision in bits 11:6, minor in bits 5:0.
// - Program counter is 15 bits, covering 32K words of 14 bits.
// - Only 8192 words exist; addresses beyond 1FFFh wrap into them.
// - Execution starts at 0000h after reset; interrupts enter at 0004h.
// - Pointer high byte bit 7 set makes an indirect read target program memory.
// - Indirect program read returns only the low eight bits of the word.
// - Indirect writes to program addresses do not touch program memory.
// - Indirect program reads take one extra instruction cycle.
// - Both region enables at one decode all user flash as application.
// - Enabled boot region runs from 0000h to its size end; application follows.
// - Enabled storage region takes the top 128 words; application ends 80h below.
// - Fetches from the enabled storage region are not allowed to execute.
// - Writes to protected blocks leave memory unchanged and set the write error.
// - Executing from an invalid area causes violation reset and clears its flag.
// - Size code picks the boot end address, capped at half the memory.
// - Write lock bits are active low; zero protects app, boot or config block.
// - Once set, write protection stays until a bulk erase or a reset.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pmp_map
   import pmp_pkg::*;
#(
   parameter logic [11:0] PART_CODE = PMP_PART_CODE_DFLT,
   parameter logic [5:0]  MAJOR_REV = PMP_MAJOR_DFLT,
   parameter logic [5:0]  MINOR_REV = PMP_MINOR_DFLT
)
(
   // Clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_N_IN,
   // Avalon-MM register slave
   input  wire logic [17:0] AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   input  wire logic [3:0]  AVS_BYTEENABLE_IN,
   output logic [31:0]      AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   // Core fetch path
   input  wire logic        EXEC_IN,
   input  wire logic        PC_STEP_IN,
   input  wire logic        PC_LOAD_IN,
   input  wire logic [14:0] PC_TARGET_IN,
   input  wire logic        IRQ_ENTRY_IN,
   output logic [14:0]      PC_OUT,
   output logic [12:0]      FETCH_ADDR_OUT,
   output logic             MV_RESET_OUT,
   // Core indirect access
   input  wire logic        IND_REQ_IN,
   input  wire logic        IND_WRITE_IN,
   input  wire logic [15:0] IND_PTR_IN,
   output logic             IND_BUSY_OUT,
   output logic             IND_VALID_OUT,
   output logic [7:0]       IND_DATA_OUT,
   output logic             DMEM_SEL_OUT,
   // Program memory read port
   input  wire logic [13:0] PMEM_DATA_IN,
   output logic             PMEM_RD_OUT,
   output logic [12:0]      PMEM_ADDR_OUT,
   // Nonvolatile write controller
   input  wire logic        NVM_WR_REQ_IN,
   input  wire logic [15:0] NVM_WR_ADDR_IN,
   input  wire logic        BULK_ERASE_IN,
   output logic             NVM_GO_OUT,
   output logic [15:0]      NVM_ADDR_OUT
);

   pmp_state_t st_r;
   pmp_state_t st_nxt;

   logic [15:0] idx;
   logic        pc_boot;
   logic        pc_app;
   logic        pc_store;
   logic        nv_boot;
   logic        nv_app;
   logic        nv_store;
   logic        fetch_bad;
   logic        nvm_ok;

   assign idx = AVS_ADDRESS_IN[17:2];

   // Read value of one register word
   function automatic logic [31:0] reg_read(input logic [15:0] i, input pmp_state_t s);
      logic [31:0] v;
      v = '0;
      unique case (i)
         PMP_IDX_DEV:  v = {18'h00000, PMP_DEV_TOP, PART_CODE};
         PMP_IDX_REV:  v = {18'h00000, PMP_REV_TOP, MAJOR_REV, MINOR_REV};
         PMP_IDX_CFG:  v = {22'h000000, s.cfg};
         PMP_IDX_STAT: v = {30'h00000000, s.exec_ok, s.wr_err};
         default:      v = '0;
      endcase
      return v;
   endfunction

   // Byte lane mask for a low-bits register
   function automatic logic [9:0] lane_mask(input logic [3:0] be);
      return {{2{be[1]}}, {8{be[0]}}};
   endfunction

   // Same boundaries for execution and write checks
   pmp_part_dec u_pc_dec (
      .addr_in       (st_r.pc[12:0]),
      .boot_en_n_in  (st_r.cfg[PMP_CFG_BOOT_EN_N]),
      .store_en_n_in (st_r.cfg[PMP_CFG_STORE_EN_N]),
      .size_in       (st_r.cfg[PMP_CFG_SIZE_LSB +: 3]),
      .in_boot_out   (pc_boot),
      .in_app_out    (pc_app),
      .in_store_out  (pc_store)
   );

   pmp_part_dec u_nv_dec (
      .addr_in       (NVM_WR_ADDR_IN[12:0]),
      .boot_en_n_in  (st_r.cfg[PMP_CFG_BOOT_EN_N]),
      .store_en_n_in (st_r.cfg[PMP_CFG_STORE_EN_N]),
      .size_in       (st_r.cfg[PMP_CFG_SIZE_LSB +: 3]),
      .in_boot_out   (nv_boot),
      .in_app_out    (nv_app),
      .in_store_out  (nv_store)
   );

   always_comb begin
      fetch_bad = pc_store;
      if (NVM_WR_ADDR_IN[PMP_HIGH_BIT]) begin
         nvm_ok = (NVM_WR_ADDR_IN >= PMP_CFG_FIRST) && (NVM_WR_ADDR_IN <= PMP_CFG_LAST)
                  && st_r.cfg[PMP_CFG_CFG_LOCK_N];
      end else begin
         nvm_ok = !(nv_boot && !st_r.cfg[PMP_CFG_BOOT_LOCK_N])
                  && !(nv_app && !st_r.cfg[PMP_CFG_APP_LOCK_N]);
      end
   end

   always_comb begin
      logic [9:0] m;
      logic [9:0] w;
      m = '0;
      w = '0;
      st_nxt           = st_r;
      st_nxt.waitreq   = 1'b1;
      st_nxt.pm_rd     = 1'b0;
      st_nxt.ind_busy  = 1'b0;
      st_nxt.ind_valid = 1'b0;
      st_nxt.dmem_sel  = 1'b0;
      st_nxt.nvm_go    = 1'b0;
      st_nxt.mv_reset  = 1'b0;

      // Bus: answer one cycle after the request is seen
      if ((AVS_READ_IN || AVS_WRITE_IN) && st_r.waitreq) begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata   = reg_read(idx, st_r);
      end
      if (AVS_WRITE_IN && !st_r.waitreq) begin
         m = lane_mask(AVS_BYTEENABLE_IN);
         if (idx == PMP_IDX_CFG) begin
            w = (AVS_WRITEDATA_IN[9:0] & m) | (st_r.cfg & ~m);
            // Size only changes while the boot region is off
            if (!st_r.cfg[PMP_CFG_BOOT_EN_N]) begin
               w = (w & ~PMP_CFG_SIZE_MASK) | (st_r.cfg & PMP_CFG_SIZE_MASK);
            end
            // Lock bits can only be cleared by software
            w = (w & ~PMP_CFG_LOCK_MASK) | (w & st_r.cfg & PMP_CFG_LOCK_MASK);
            st_nxt.cfg = w;
         end else if (idx == PMP_IDX_STAT) begin
            if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[PMP_ST_WR_ERR]) begin
               st_nxt.wr_err = 1'b0;
            end
            if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[PMP_ST_EXEC_OK]) begin
               st_nxt.exec_ok = 1'b1;
            end
         end
      end
      if (BULK_ERASE_IN) begin
         st_nxt.cfg = PMP_CFG_RESET;
      end

      // Nonvolatile write screening; the error set wins over a clear
      if (NVM_WR_REQ_IN) begin
         if (nvm_ok) begin
            st_nxt.nvm_go   = 1'b1;
            st_nxt.nvm_addr = NVM_WR_ADDR_IN;
         end else begin
            st_nxt.wr_err = 1'b1;
         end
      end

      // Program counter; violation beats every other change
      if (EXEC_IN && fetch_bad) begin
         st_nxt.mv_reset = 1'b1;
         st_nxt.exec_ok  = 1'b0;
         st_nxt.pc       = PMP_RESET_VEC;
      end else if (IRQ_ENTRY_IN) begin
         st_nxt.pc = PMP_IRQ_VEC;
      end else if (PC_LOAD_IN) begin
         st_nxt.pc = PC_TARGET_IN;
      end else if (PC_STEP_IN) begin
         st_nxt.pc = 15'(st_r.pc + 15'h0001);
      end
      st_nxt.fetch_addr = st_nxt.pc[12:0];

      // Indirect access
      unique case (st_r.ind)
         PMP_IND_IDLE: begin
            if (IND_REQ_IN) begin
               if (IND_PTR_IN[PMP_HIGH_BIT]) begin
                  if (!IND_WRITE_IN) begin
                     st_nxt.ind      = PMP_IND_WAIT;
                     st_nxt.pm_rd    = 1'b1;
                     st_nxt.pm_addr  = IND_PTR_IN[12:0];
                     st_nxt.ind_busy = 1'b1;
                  end
               end else begin
                  st_nxt.dmem_sel = 1'b1;
               end
            end
         end
         PMP_IND_WAIT: begin
            st_nxt.ind       = PMP_IND_IDLE;
            st_nxt.ind_valid = 1'b1;
            st_nxt.ind_data  = PMEM_DATA_IN[7:0];
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st_r <= PMP_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign AVS_READDATA_OUT    = st_r.rdata;
   assign AVS_WAITREQUEST_OUT = st_r.waitreq;
   assign PC_OUT              = st_r.pc;
   assign FETCH_ADDR_OUT      = st_r.fetch_addr;
   assign MV_RESET_OUT        = st_r.mv_reset;
   assign IND_BUSY_OUT        = st_r.ind_busy;
   assign IND_VALID_OUT       = st_r.ind_valid;
   assign IND_DATA_OUT        = st_r.ind_data;
   assign DMEM_SEL_OUT        = st_r.dmem_sel;
   assign PMEM_RD_OUT         = st_r.pm_rd;
   assign PMEM_ADDR_OUT       = st_r.pm_addr;
   assign NVM_GO_OUT          = st_r.nvm_go;
   assign NVM_ADDR_OUT        = st_r.nvm_addr;

   // Checks

   AST_DEV_WORD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (AVS_READ_IN && !st_r.waitreq && idx == PMP_IDX_DEV)
      |-> (st_r.rdata[13:12] == PMP_DEV_TOP && st_r.rdata[11:0] == PART_CODE))
      else $error("identity word read wrong");

   AST_REV_TOP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (AVS_READ_IN && !st_r.waitreq && idx == PMP_IDX_REV)
      |-> (st_r.rdata[13] && !st_r.rdata[12]))
      else $error("revision word top bits wrong");

   AST_REV_FIELDS: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (AVS_READ_IN && !st_r.waitreq && idx == PMP_IDX_REV)
      |-> (st_r.rdata[11:6] == MAJOR_REV && st_r.rdata[5:0] == MINOR_REV))
      else $error("revision fields wrong");

   AST_WRAP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (PC_STEP_IN && !PC_LOAD_IN && !IRQ_ENTRY_IN && !EXEC_IN)
      |=> (FETCH_ADDR_OUT == 13'($past(st_r.pc) + 15'h0001)))
      else $error("fetch address does not wrap");

   AST_IRQ_VEC: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (IRQ_ENTRY_IN && !(EXEC_IN && fetch_bad)) |=> (PC_OUT == PMP_IRQ_VEC))
      else $error("interrupt entry not at vector");

   AST_IND_CYCLE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (st_r.ind == PMP_IND_IDLE && IND_REQ_IN && IND_PTR_IN[PMP_HIGH_BIT] && !IND_WRITE_IN)
      |=> (IND_BUSY_OUT && PMEM_RD_OUT && !IND_VALID_OUT) ##1 (IND_VALID_OUT && !IND_BUSY_OUT))
      else $error("indirect program read timing wrong");

   AST_IND_LOW8: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      IND_VALID_OUT |-> (IND_DATA_OUT == $past(PMEM_DATA_IN[7:0])))
      else $error("indirect data not low byte");

   AST_IND_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (st_r.ind == PMP_IND_IDLE && IND_REQ_IN && IND_PTR_IN[PMP_HIGH_BIT] && IND_WRITE_IN)
      |=> (!PMEM_RD_OUT && !IND_BUSY_OUT && !DMEM_SEL_OUT))
      else $error("indirect program write acted");

   AST_PROTECT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (NVM_WR_REQ_IN && !nvm_ok) |=> (!NVM_GO_OUT && st_r.wr_err))
      else $error("protected write not refused");

   AST_STORE_EXEC: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (EXEC_IN && pc_store) |=> (MV_RESET_OUT && !st_r.exec_ok && PC_OUT == PMP_RESET_VEC))
      else $error("storage execution not trapped");

   AST_LOCK_STICKY: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (!st_r.cfg[PMP_CFG_APP_LOCK_N] && !BULK_ERASE_IN) |=> !st_r.cfg[PMP_CFG_APP_LOCK_N])
      else $error("write lock released");

   AST_ALL_APP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (st_r.cfg[PMP_CFG_BOOT_EN_N] && st_r.cfg[PMP_CFG_STORE_EN_N]) |-> pc_app)
      else $error("default partition not application");

   AST_STORE_SPAN: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (!st_r.cfg[PMP_CFG_STORE_EN_N])
      |-> (pc_store == (st_r.pc[12:0] > PMP_LAST_ADDR - PMP_STORE_SPAN)))
      else $error("storage region bounds wrong");

   AST_BOOT_APP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (!st_r.cfg[PMP_CFG_BOOT_EN_N] && st_r.pc[12:0] == 13'h0000) |-> (pc_boot && !pc_app))
      else $error("boot region does not start at zero");

   AST_DATA_PTR: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (st_r.ind == PMP_IND_IDLE && IND_REQ_IN && !IND_PTR_IN[PMP_HIGH_BIT])
      |=> (DMEM_SEL_OUT && !PMEM_RD_OUT && !IND_BUSY_OUT))
      else $error("data pointer not sent to data memory");

   AST_IND_ADDR: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (st_r.ind == PMP_IND_IDLE && IND_REQ_IN && IND_PTR_IN[PMP_HIGH_BIT] && !IND_WRITE_IN)
      |=> (PMEM_ADDR_OUT == $past(IND_PTR_IN[12:0]) && !DMEM_SEL_OUT))
      else $error("program read address wrong");

   AST_BOOT_END: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (!st_r.cfg[PMP_CFG_BOOT_EN_N] && st_r.cfg[PMP_CFG_SIZE_LSB +: 3] == PMP_BSZ_512)
      |-> (nv_boot == (NVM_WR_ADDR_IN[12:0] <= PMP_BOOT_END_512)))
      else $error("smallest boot region bounds wrong");

   AST_BOOT_CAP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (!st_r.cfg[PMP_CFG_BOOT_EN_N] && st_r.cfg[PMP_CFG_SIZE_LSB +: 3] == PMP_BSZ_8K)
      |-> (nv_boot == (NVM_WR_ADDR_IN[12:0] <= PMP_BOOT_END_HALF)))
      else $error("boot region not capped at half");

   AST_STORE_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (NVM_WR_REQ_IN && !NVM_WR_ADDR_IN[PMP_HIGH_BIT] && nv_store) |=> NVM_GO_OUT)
      else $error("storage region write refused");

   AST_APP_LOCK: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (NVM_WR_REQ_IN && !NVM_WR_ADDR_IN[PMP_HIGH_BIT] && nv_app
       && !st_r.cfg[PMP_CFG_APP_LOCK_N]) |=> (!NVM_GO_OUT && st_r.wr_err))
      else $error("locked application block written");

   AST_PC_LOAD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (PC_LOAD_IN && !IRQ_ENTRY_IN && !(EXEC_IN && fetch_bad)) |=> (PC_OUT == $past(PC_TARGET_IN)))
      else $error("program counter load wrong");

endmodule

// ===== dv/pmp_pmem_model.sv
// Program memory model answering the partition map's read port
`timescale 1ns/10ps
module pmp_pmem_model
   import pmp_pkg::*;
(
   // Clock and read port
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   input  wire logic [12:0] addr_in,
   output logic [13:0]      data_out
);
   logic [13:0] last_r = 14'h0000;
   // Word derived from its address; outside a read the lines toggle every cycle
   always_comb data_out = rd_in ? {1'b1, addr_in ^ 13'h15a3} : ~last_r;
   always_ff @(posedge clk_in) last_r <= data_out;
endmodule

// ===== dv/tb_top.sv
// Self-checking testbench of the program memory partition map
`timescale 1ns/10ps
module tb_top
   import pmp_pkg::*;
;
   // Identity values, arbitrary
   localparam logic [11:0] CODE = 12'h3c5;
   localparam logic [5:0]  MAJ  = 6'h2a;
   localparam logic [5:0]  MIN  = 6'h15;
   logic        clk, rst_n, rd, wr, exec, step, ld, irq, ireq, iwr, nreq, bulk, av_wait;
   logic        mv, ibusy, ivalid, dsel, prd, ngo;
   logic [17:0] addr;
   logic [31:0] wd, av_rdata, r;
   logic [14:0] tgt, pc;
   logic [15:0] iptr, naddr, nad, c1;
   logic [13:0] pdat, w;
   logic [12:0] fa, paddr;
   logic [7:0]  idata;
   logic [8:0]  c2;
   logic [12:0] ends [5];
   int          failures, total_checks;

   pmp_map #(.PART_CODE(CODE), .MAJOR_REV(MAJ), .MINOR_REV(MIN)) i_pmp_map (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(av_rdata), .AVS_WAITREQUEST_OUT(av_wait), .EXEC_IN(exec),
      .PC_STEP_IN(step), .PC_LOAD_IN(ld), .PC_TARGET_IN(tgt), .IRQ_ENTRY_IN(irq),
      .PC_OUT(pc), .FETCH_ADDR_OUT(fa), .MV_RESET_OUT(mv), .IND_REQ_IN(ireq),
      .IND_WRITE_IN(iwr), .IND_PTR_IN(iptr), .IND_BUSY_OUT(ibusy), .IND_VALID_OUT(ivalid),
      .IND_DATA_OUT(idata), .DMEM_SEL_OUT(dsel), .PMEM_DATA_IN(pdat), .PMEM_RD_OUT(prd),
      .PMEM_ADDR_OUT(paddr), .NVM_WR_REQ_IN(nreq), .NVM_WR_ADDR_IN(naddr),
      .BULK_ERASE_IN(bulk), .NVM_GO_OUT(ngo), .NVM_ADDR_OUT(nad));

   pmp_pmem_model i_pmp_pmem_model (.clk_in(clk), .rd_in(prd), .addr_in(paddr),
      .data_out(pdat));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Avalon access: hold the request until waitrequest is sampled low
   task automatic av(input logic w_en, input logic [15:0] idx, input logic [31:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      rd <= !w_en;
      wr <= w_en;
      wd <= d;
      do
         @(posedge clk);
      while (av_wait !== 1'b0);
      r = av_rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic core(input logic e, s, l, q, input logic [14:0] t);
      @(posedge clk);
      {exec, step, ld, irq} <= {e, s, l, q};
      tgt <= t;
      @(posedge clk);
      {exec, step, ld, irq} <= 4'h0;
      @(negedge clk);
   endtask

   task automatic ind(input logic wr_en, input logic [15:0] p);
      @(posedge clk);
      ireq <= 1'b1;
      iwr <= wr_en;
      iptr <= p;
      @(posedge clk);
      ireq <= 1'b0;
      @(negedge clk);
      c1 = {prd, ibusy, dsel, paddr};
      @(negedge clk);
      c2 = {ivalid, idata};
   endtask

   task automatic nvm(input logic [15:0] a, input logic go);
      @(posedge clk);
      nreq <= 1'b1;
      naddr <= a;
      @(posedge clk);
      nreq <= 1'b0;
      @(negedge clk);
      chk({31'h0, ngo}, {31'h0, go});
      if (go)
         chk({16'h0, nad}, {16'h0, a});
   endtask

   task automatic erase;
      @(posedge clk);
      bulk <= 1'b1;
      @(posedge clk);
      bulk <= 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end

   initial begin
      {rst_n, rd, wr, exec, step, ld, irq, ireq, iwr, nreq, bulk} = '0;
      addr = '0;
      wd = '0;
      tgt = '0;
      iptr = '0;
      naddr = '0;
      failures = 0;
      total_checks = 0;
      ends = '{13'h01ff, 13'h03ff, 13'h07ff, 13'h0fff, 13'h0fff};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({17'h0, pc}, 32'h0);
      av(0, PMP_IDX_CFG, 0);
      chk(r, 32'h39f);
      av(1, PMP_IDX_DEV, 0);
      av(0, PMP_IDX_DEV, 0);
      chk(r, {18'h0, 2'b11, CODE});
      av(0, PMP_IDX_REV, 0);
      chk(r, {18'h0, 2'b10, MAJ, MIN});
      av(0, 16'h0123, 0);
      chk(r, 32'h0);
      core(0, 0, 1, 0, 15'h7ffe);
      chk({17'h0, pc}, 32'h7ffe);
      chk({19'h0, fa}, 32'h1ffe);
      core(0, 1, 0, 0, 0);
      core(0, 1, 0, 0, 0);
      chk({17'h0, pc}, 32'h0);
      core(0, 0, 0, 1, 0);
      chk({17'h0, pc}, 32'h4);
      // Program read through the pointer, upper pointer bits wrap away
      ind(0, 16'hfabc);
      w = {1'b1, 13'h1abc ^ 13'h15a3};
      chk({16'h0, c1}, {16'h0, 3'b110, 13'h1abc});
      chk({23'h0, c2}, {23'h0, 1'b1, w[7:0]});
      ind(0, 16'h0123);
      chk({28'h0, c1[15:13], c2[8]}, 32'h2);
      ind(1, 16'h8123);
      chk({28'h0, c1[15:13], c2[8]}, 32'h0);
      core(0, 0, 1, 0, 15'h1f80);
      core(1, 0, 0, 0, 0);
      chk({31'h0, mv}, 32'h0);
      av(1, PMP_IDX_CFG, 32'h38f);
      nvm(16'h1f80, 1);
      core(0, 0, 1, 0, 15'h1f7f);
      core(1, 0, 0, 0, 0);
      chk({31'h0, mv}, 32'h0);
      core(0, 0, 1, 0, 15'h7f80);
      core(1, 0, 0, 0, 0);
      chk({16'h0, mv, pc}, 32'h8000);
      av(0, PMP_IDX_STAT, 0);
      chk(r & 32'h2, 32'h0);
      erase();
      av(1, PMP_IDX_CFG, 32'h317);
      nvm(16'h01ff, 1);
      nvm(16'h0200, 0);
      av(0, PMP_IDX_STAT, 0);
      chk(r & 32'h1, 32'h1);
      nvm(PMP_IDX_DEV, 0);
      av(1, PMP_IDX_CFG, 32'h39f);
      av(0, PMP_IDX_CFG, 0);
      chk(r & 32'h80, 32'h0);
      nvm(16'h0200, 0);
      erase();
      av(0, PMP_IDX_CFG, 0);
      chk(r, 32'h39f);
      nvm(16'h0200, 1);
      av(1, PMP_IDX_CFG, 32'h19f);
      nvm(16'h800b, 0);
      erase();
      nvm(16'h8007, 1);
      // Boot size codes 7 down to 3, boot region locked and application open
      for (int i = 0; i < 5; i++) begin
         erase();
         av(1, PMP_IDX_CFG, 32'h298 | (7 - i));
         av(1, PMP_IDX_CFG, 32'h290 | (7 - i));
         nvm({3'h0, ends[i]}, 0);
         nvm({3'h0, ends[i] + 13'h0001}, 1);
      end
      finish_test();
   end
endmodule
